// ### shared/tcs_pkg.sv
package tcs_pkg;

  localparam int NUM_TARIFF  = 4;
  localparam int NUM_SEASON  = 4;
  localparam int NUM_GROUP   = 4;
  localparam int NUM_SPOT    = 4;
  localparam int NUM_HOLIDAY = 20;
  localparam int NUM_WEEKDAY = 7;

  // tariff code 0 is T1
  localparam logic [1:0] TARIFF_RST = 2'h0;
  localparam logic [1:0] TARIFF_T1  = 2'h0;

  // season code 0 is season one
  localparam logic [1:0] SEASON_RST = 2'h0;
  localparam logic [1:0] SEASON_ONE = 2'h0;

  typedef struct packed {
    logic [3:0] month;
    logic [4:0] day;
  } tcs_date_t;

  typedef struct packed {
    logic       valid;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [1:0] tariff;
  } tcs_spot_t;

  typedef struct packed {
    logic [NUM_WEEKDAY-1:0] weekdays;
    logic                   holiday;
    tcs_spot_t [NUM_SPOT-1:0] spots;
  } tcs_group_t;

  typedef struct packed {
    logic                       start_valid;
    tcs_date_t                  start;
    tcs_group_t [NUM_GROUP-1:0] groups;
  } tcs_season_t;

  typedef struct packed {
    logic      valid;
    tcs_date_t date;
  } tcs_holiday_t;

  typedef struct packed {
    tcs_date_t  date;
    logic [2:0] weekday;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } tcs_rtc_t;

endpackage

// ### design/tcs_holiday_match.sv
`timescale 1ns/100ps
module tcs_holiday_match #(
  parameter int N = tcs_pkg::NUM_HOLIDAY
) (
  // stored dates and today
  input  wire tcs_pkg::tcs_holiday_t [N-1:0] i_holidays,
  input  wire tcs_pkg::tcs_date_t            i_today,
  // match
  output logic                               o_hit
);

  // day and month only, so a holiday repeats every year
  always_comb begin
    o_hit = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (i_holidays[i].valid && i_holidays[i].date == i_today) begin
        o_hit = 1'b1;
      end
    end
  end

endmodule // tcs_holiday_match

// ### design/tcs_pick.sv
`timescale 1ns/100ps
module tcs_pick #(
  parameter int N  = 4,
  parameter int KW = 9,
  parameter int IW = (N > 1) ? $clog2(N) : 1
) (
  // candidates
  input  wire logic [N-1:0][KW-1:0] i_key,
  input  wire logic [N-1:0]         i_valid,
  input  wire logic [KW-1:0]        i_cur,
  // winner
  output logic [IW-1:0]             o_idx,
  output logic                      o_found
);

  logic [KW-1:0] le_key;
  logic [KW-1:0] all_key;
  logic [IW-1:0] le_idx;
  logic [IW-1:0] all_idx;
  logic          have_le;

  // ascending scan with >= so the higher index wins equal keys
  always_comb begin
    le_key  = '0;
    all_key = '0;
    le_idx  = '0;
    all_idx = '0;
    have_le = 1'b0;
    o_found = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (i_valid[i]) begin
        if (i_key[i] <= i_cur && (!have_le || i_key[i] >= le_key)) begin
          le_key  = i_key[i];
          le_idx  = IW'(i);
          have_le = 1'b1;
        end
        if (!o_found || i_key[i] >= all_key) begin
          all_key = i_key[i];
          all_idx = IW'(i);
          o_found = 1'b1;
        end
      end
    end
  end

  // before every key: wrap to the latest one
  assign o_idx = have_le ? le_idx : all_idx;

endmodule // tcs_pick

// ### design/tcs_tariff_selector.sv
`timescale 1ns/100ps
module tcs_tariff_selector (
  // clock and reset
  input  wire logic                                       i_clk,
  input  wire logic                                       i_arst_n,
  // settings
  input  wire tcs_pkg::tcs_season_t [tcs_pkg::NUM_SEASON-1:0]   i_seasons,
  input  wire tcs_pkg::tcs_holiday_t [tcs_pkg::NUM_HOLIDAY-1:0] i_holidays,
  // real-time clock
  input  wire tcs_pkg::tcs_rtc_t                          i_rtc,
  input  wire logic                                       i_rtc_sec_tick,
  // source selection
  input  wire logic                                       i_src_inputs,
  input  wire logic [1:0]                                 i_tariff_in,
  input  wire logic                                       i_fixed_en,
  input  wire logic [1:0]                                 i_fixed_tariff,
  // energy counter gating
  input  wire logic                                       i_energy_pulse,
  output logic [tcs_pkg::NUM_TARIFF-1:0]                  o_count_en,
  // active tariff, 0 is T1
  output logic [1:0]                                      o_tariff,
  output logic [1:0]                                      o_season
);

  localparam int NS   = tcs_pkg::NUM_SEASON;
  localparam int NG   = tcs_pkg::NUM_GROUP;
  localparam int NP   = tcs_pkg::NUM_SPOT;
  localparam int NC   = NG * NP;
  localparam int DKW  = 9;
  localparam int TKW  = 11;

  ////////////////////////////////////////////////////////////////////////////
  // season resolution

  logic [NS-1:0][DKW-1:0] s_key;
  logic [NS-1:0]          s_val;
  logic [1:0]             s_idx;
  logic                   s_found;
  wire  [DKW-1:0]         today_key = i_rtc.date;

  // each season's optional start date as a month/day key
  for (genvar s = 0; s < NS; s++) begin : g_season
    assign s_key[s] = i_seasons[s].start;
    assign s_val[s] = i_seasons[s].start_valid;
  end

  tcs_pick #(
    .N   (NS),
    .KW  (DKW),
    .IW  (2)
  ) u_season_pick (
    .i_key   (s_key),
    .i_valid (s_val),
    .i_cur   (today_key),
    .o_idx   (s_idx),
    .o_found (s_found)
  );

  // no start date at all falls back to season one
  wire [1:0] season_sel = s_found ? s_idx : tcs_pkg::SEASON_ONE;
  wire tcs_pkg::tcs_season_t act = i_seasons[season_sel];

  ////////////////////////////////////////////////////////////////////////////
  // day groups

  logic hol_hit;

  tcs_holiday_match #(
    .N (tcs_pkg::NUM_HOLIDAY)
  ) u_holiday (
    .i_holidays (i_holidays),
    .i_today    (i_rtc.date),
    .o_hit      (hol_hit)
  );

  logic [NG-1:0] grp_act;
  logic [NG-1:0] grp_hol;
  logic [NG-1:0] grp_wday;

  // holiday match overrides the weekday selection
  for (genvar g = 0; g < NG; g++) begin : g_group
    assign grp_hol[g]  = act.groups[g].holiday;
    assign grp_wday[g] = act.groups[g].weekdays[i_rtc.weekday];
    assign grp_act[g]  = hol_hit ? grp_hol[g] : grp_wday[g];
  end

  ////////////////////////////////////////////////////////////////////////////
  // time spots

  logic [NC-1:0][TKW-1:0] c_key;
  logic [NC-1:0]          c_val;
  logic [NC-1:0][1:0]     c_tariff;
  logic [3:0]             c_idx;
  logic                   c_found;
  wire  [TKW-1:0]         now_key = {i_rtc.hour, i_rtc.minute};

  // merged set; a later group's spot carries a higher successive number
  for (genvar g = 0; g < NG; g++) begin : g_cg
    for (genvar p = 0; p < NP; p++) begin : g_cp
      assign c_key[g*NP+p]    = {act.groups[g].spots[p].hour,
                                 act.groups[g].spots[p].minute};
      assign c_val[g*NP+p]    = grp_act[g] & act.groups[g].spots[p].valid;
      assign c_tariff[g*NP+p] = act.groups[g].spots[p].tariff;
    end
  end

  tcs_pick #(
    .N   (NC),
    .KW  (TKW),
    .IW  (4)
  ) u_spot_pick (
    .i_key   (c_key),
    .i_valid (c_val),
    .i_cur   (now_key),
    .o_idx   (c_idx),
    .o_found (c_found)
  );

  // nothing valid for today falls back to T1
  wire [1:0] clk_tariff = c_found ? c_tariff[c_idx] : tcs_pkg::TARIFF_T1;

  ////////////////////////////////////////////////////////////////////////////
  // source selection and output register

  // fixed tariff from communication beats both automatic sources
  wire [1:0] src_tariff = i_fixed_en   ? i_fixed_tariff :
                          i_src_inputs ? i_tariff_in    : clk_tariff;
  // the clock path only moves on a new second; other sources follow at once
  wire       load       = i_fixed_en | i_src_inputs | i_rtc_sec_tick;

  logic [1:0] tariff_ff;
  logic [1:0] nxt_tariff;
  logic [1:0] season_ff;
  logic [1:0] nxt_season;

  assign nxt_tariff = load ? src_tariff : tariff_ff;
  assign nxt_season = i_rtc_sec_tick ? season_sel : season_ff;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tariff_ff <= tcs_pkg::TARIFF_RST;
      season_ff <= tcs_pkg::SEASON_RST;
    end else begin
      tariff_ff <= nxt_tariff;
      season_ff <= nxt_season;
    end
  end

  assign o_tariff = tariff_ff;
  assign o_season = season_ff;

  // only the active tariff's counter sees the energy pulse
  for (genvar t = 0; t < tcs_pkg::NUM_TARIFF; t++) begin : g_cnt
    assign o_count_en[t] = i_energy_pulse & (tariff_ff == 2'(t));
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertion helpers

  // an order-free view of both picks, so the checks below do not
  // repeat the scanning loop that they guard
  logic [NS-1:0] s_after;
  logic [NS-1:0] s_closer;
  logic [NS-1:0] s_later;
  logic [NS-1:0] s_tie_hi;
  logic [NC-1:0] c_after;
  logic [NC-1:0] c_closer;
  logic [NC-1:0] c_later;
  logic [NC-1:0] c_tie_hi;
  logic [NC-1:0] hol_mask;
  logic [NC-1:0] wday_mask;

  // valid starts still to come, nearer than the pick, later than the pick
  for (genvar s = 0; s < NS; s++) begin : g_s_chk
    assign s_after[s]  = s_val[s] & (s_key[s] > today_key);
    assign s_closer[s] = s_val[s] & ~s_after[s] & (s_key[s] > s_key[season_sel]);
    assign s_later[s]  = s_val[s] & (s_key[s] > s_key[season_sel]);
    assign s_tie_hi[s] = s_val[s] & (s_key[s] == s_key[season_sel]) & (2'(s) > season_sel);
  end

  // the same per spot, plus group masks taken straight from the settings
  for (genvar i = 0; i < NC; i++) begin : g_c_chk
    assign c_after[i]   = c_val[i] & (c_key[i] > now_key);
    assign c_closer[i]  = c_val[i] & ~c_after[i] & (c_key[i] > c_key[c_idx]);
    assign c_later[i]   = c_val[i] & (c_key[i] > c_key[c_idx]);
    assign c_tie_hi[i]  = c_val[i] & (c_key[i] == c_key[c_idx]) & (4'(i) > c_idx);
    assign hol_mask[i]  = act.groups[i/NP].holiday;
    assign wday_mask[i] = act.groups[i/NP].weekdays[i_rtc.weekday];
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence clock_src_tick;
    !i_fixed_en && !i_src_inputs && i_rtc_sec_tick;
  endsequence

  sequence clock_src_idle;
    !i_fixed_en && !i_src_inputs && !i_rtc_sec_tick;
  endsequence

  sequence season_started;
    (s_val & ~s_after) != '0;
  endsequence

  sequence season_wrapped;
    s_found && (s_val & ~s_after) == '0;
  endsequence

  sequence spot_started;
    (c_val & ~c_after) != '0;
  endsequence

  sequence spot_wrapped;
    c_found && (c_val & ~c_after) == '0;
  endsequence

  a_count_one_hot: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_energy_pulse |-> $onehot(o_count_en) && o_count_en[o_tariff])
    else $error("energy pulse not routed to the active tariff only");

  a_count_idle: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !i_energy_pulse |-> o_count_en == '0)
    else $error("counter enabled without an energy pulse");

  a_tick_updates: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    clock_src_tick |=> o_tariff == $past(clk_tariff))
    else $error("tariff clock result not registered after tick");

  a_hold_between: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    clock_src_idle |=> $stable(o_tariff))
    else $error("tariff changed without a new second");

  a_input_decode: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (!i_fixed_en && i_src_inputs) |=> o_tariff == $past(i_tariff_in))
    else $error("tariff inputs not decoded to the tariff");

  a_fixed_wins: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_fixed_en |=> o_tariff == $past(i_fixed_tariff))
    else $error("fixed tariff not applied");

  a_no_season_one: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (s_val == '0) |-> season_sel == 2'h0)
    else $error("season one not chosen without start dates");

  a_season_tie: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (s_val[3] && s_key[3] == today_key) |-> season_sel == 2'h3)
    else $error("season starting today with top number not chosen");

  a_no_spot_t1: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (c_val == '0) |-> clk_tariff == tcs_pkg::TARIFF_T1)
    else $error("tariff one not chosen without a valid spot");

  a_holiday_grp: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    hol_hit |-> grp_act == grp_hol)
    else $error("holiday day groups not selected on holiday");

  a_weekday_grp: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !hol_hit |-> grp_act == grp_wday)
    else $error("weekday day groups not selected");

  a_season_recent: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    season_started |-> s_val[season_sel] && !s_after[season_sel] && s_closer == '0)
    else $error("active season is not the latest start so far");

  a_season_wrap: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    season_wrapped |-> s_val[season_sel] && s_later == '0)
    else $error("season with the latest start not chosen before all starts");

  a_season_order: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    s_found |-> s_tie_hi == '0)
    else $error("lower season chosen on an equal start date");

  a_spot_recent: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    spot_started |-> c_val[c_idx] && !c_after[c_idx] && c_closer == '0)
    else $error("active spot is not the latest one so far today");

  a_spot_wrap: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    spot_wrapped |-> c_val[c_idx] && c_later == '0)
    else $error("latest spot of the day not chosen before all spots");

  a_spot_tie: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    c_found |-> c_tie_hi == '0)
    else $error("lower spot chosen on an equal time");

  a_hol_spots: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    hol_hit |-> (c_val & ~hol_mask) == '0)
    else $error("spot of a non-holiday group competes on a holiday");

  a_wday_spots: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !hol_hit |-> (c_val & ~wday_mask) == '0)
    else $error("spot of a group without today's weekday competes");

  a_hol_empty: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (hol_hit && grp_hol == '0) |-> clk_tariff == tcs_pkg::TARIFF_T1)
    else $error("tariff one not chosen on a holiday with no holiday group");

  a_season_reg: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_rtc_sec_tick |=> o_season == $past(season_sel))
    else $error("season not registered after tick");

  a_season_hold: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !i_rtc_sec_tick |=> $stable(o_season))
    else $error("season changed without a new second");

endmodule // tcs_tariff_selector

// ### dv/tcs_rtc_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////
// real-time clock and energy counters facing the selector
module tcs_rtc_model (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_arst_n,
  // time load from the bench
  input  wire logic              i_load,
  input  wire tcs_pkg::tcs_rtc_t i_set,
  // counter enables
  input  wire logic [3:0]        i_count_en,
  // clock face and counters
  output tcs_pkg::tcs_rtc_t      o_rtc,
  output logic                   o_tick,
  output logic [3:0][7:0]        o_counts
);
  tcs_pkg::tcs_rtc_t rtc_ff;
  logic              tick_ff;
  logic [3:0][7:0]   cnt_ff;

  // time moves only with a tick, as a real rtc does
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rtc_ff  <= '0;
      tick_ff <= 1'b0;
      cnt_ff  <= '0;
    end else begin
      tick_ff <= i_load;
      if (i_load) begin
        rtc_ff <= i_set;
      end
      for (int t = 0; t < 4; t++) begin
        if (i_count_en[t]) begin
          cnt_ff[t] <= cnt_ff[t] + 8'h01;
        end
      end
    end
  end

  assign o_rtc    = rtc_ff;
  assign o_tick   = tick_ff;
  assign o_counts = cnt_ff;
endmodule // tcs_rtc_model

// ### dv/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic i_clk, i_arst_n, load, src_in, fixed_en, e_pulse, tick;
  logic [1:0] t_in, fix_t, tariff, season;
  logic [3:0] cen;
  logic [3:0][7:0] counts;
  tcs_pkg::tcs_season_t [tcs_pkg::NUM_SEASON-1:0]   seasons;
  tcs_pkg::tcs_holiday_t [tcs_pkg::NUM_HOLIDAY-1:0] hols;
  tcs_pkg::tcs_rtc_t set_v, rtc;
  int failures, total_checks;

  tcs_tariff_selector tcs_tariff_selector_inst (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_seasons(seasons), .i_holidays(hols),
    .i_rtc(rtc), .i_rtc_sec_tick(tick), .i_src_inputs(src_in), .i_tariff_in(t_in),
    .i_fixed_en(fixed_en), .i_fixed_tariff(fix_t), .i_energy_pulse(e_pulse),
    .o_count_en(cen), .o_tariff(tariff), .o_season(season));

  tcs_rtc_model tcs_rtc_model_inst (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_load(load), .i_set(set_v),
    .i_count_en(cen), .o_rtc(rtc), .o_tick(tick), .o_counts(counts));

  ////////////////////////////////////////////////////////////////
  // 200 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // load a time with its tick; the tariff lands one edge after the tick
  task automatic eval(input logic [3:0] mo, input logic [4:0] dy, input logic [2:0] wd,
                      input logic [4:0] hh, input logic [5:0] mm,
                      input logic [1:0] et, input logic [1:0] es);
    set_v = {mo, dy, wd, hh, mm, 6'h2A};
    load  = 1'b1;
    @(negedge i_clk);
    load  = 1'b0;
    @(negedge i_clk);
    chk(8'(tariff), 8'(et));
    chk(8'(season), 8'(es));
  endtask

  // watchdog, far beyond the fifty or so cycles the tests need
  initial begin
    #20000;
    failures++;
    complete_run();
  end

  initial begin
    {i_arst_n, load, src_in, fixed_en, e_pulse, t_in, fix_t} = '0;
    set_v = '0;
    seasons = '0;
    hols = '0;
    seasons[0].start_valid = 1'b1;
    seasons[0].start = {4'h2, 5'h0F};
    seasons[1].start_valid = 1'b1;
    seasons[1].start = {4'hA, 5'h1E};
    seasons[3].start_valid = 1'b1;
    seasons[3].start = {4'h6, 5'h01};
    // two weekday groups sharing 06:00, one holiday group, one empty group
    seasons[0].groups[0].weekdays = 7'h02;
    seasons[0].groups[0].spots[0] = {1'b1, 5'h06, 6'h00, 2'h1};
    seasons[0].groups[0].spots[1] = {1'b1, 5'h16, 6'h00, 2'h2};
    seasons[0].groups[1].weekdays = 7'h02;
    seasons[0].groups[1].spots[0] = {1'b1, 5'h0C, 6'h00, 2'h3};
    seasons[0].groups[1].spots[1] = {1'b1, 5'h06, 6'h00, 2'h0};
    seasons[0].groups[2].holiday  = 1'b1;
    seasons[0].groups[2].spots[3] = {1'b1, 5'h0A, 6'h00, 2'h1};
    seasons[0].groups[3].weekdays = 7'h08;
    seasons[0].groups[3].spots[0] = {1'b0, 5'h01, 6'h00, 2'h3};
    hols[19] = {1'b1, 4'h3, 5'h15};
    hols[0]  = {1'b0, 4'h3, 5'h14}; // disabled entry must not match
    hols[5]  = {1'b1, 4'hC, 5'h19}; // holiday in a season with no groups
    repeat (6) @(negedge i_clk);
    i_arst_n = 1'b1;
    chk(8'(tariff), 8'h00);
    eval(4'h3, 5'h14, 3'h1, 5'h07, 6'h00, 2'h0, 2'h0);
    eval(4'h3, 5'h14, 3'h1, 5'h0C, 6'h1E, 2'h3, 2'h0);
    eval(4'h3, 5'h14, 3'h1, 5'h17, 6'h00, 2'h2, 2'h0);
    eval(4'h3, 5'h14, 3'h1, 5'h03, 6'h00, 2'h2, 2'h0);
    eval(4'h3, 5'h15, 3'h1, 5'h0C, 6'h1E, 2'h1, 2'h0);
    eval(4'h3, 5'h14, 3'h2, 5'h0C, 6'h00, 2'h0, 2'h0);
    eval(4'h3, 5'h14, 3'h3, 5'h0C, 6'h00, 2'h0, 2'h0);
    eval(4'h1, 5'h01, 3'h0, 5'h0C, 6'h00, 2'h0, 2'h1);
    eval(4'h6, 5'h01, 3'h0, 5'h0C, 6'h00, 2'h0, 2'h3);
    eval(4'hA, 5'h1D, 3'h0, 5'h0C, 6'h00, 2'h0, 2'h3);
    eval(4'hC, 5'h1F, 3'h0, 5'h0C, 6'h00, 2'h0, 2'h1);
    eval(4'hC, 5'h19, 3'h1, 5'h0C, 6'h00, 2'h0, 2'h1);
    seasons[3].start = {4'h2, 5'h0F};
    eval(4'h3, 5'h14, 3'h1, 5'h0C, 6'h1E, 2'h0, 2'h3);
    {seasons[0].start_valid, seasons[1].start_valid, seasons[3].start_valid} = 3'h0;
    eval(4'h3, 5'h14, 3'h1, 5'h0C, 6'h1E, 2'h3, 2'h0);
    // settings change with no tick must not move the tariff
    seasons[0].groups[1].spots[0].tariff = 2'h2;
    repeat (3) @(negedge i_clk);
    chk(8'(tariff), 8'h03);
    src_in = 1'b1;
    for (int i = 0; i < 4; i++) begin
      t_in = 2'(i);
      @(negedge i_clk);
      chk(8'(tariff), 8'(i));
      e_pulse = 1'b1;
      #1;
      chk(8'(cen), 8'(4'h1 << i));
      @(negedge i_clk);
      e_pulse = 1'b0;
    end
    for (int i = 0; i < 4; i++) chk(counts[i], 8'h01);
    fixed_en = 1'b1;
    fix_t    = 2'h2;
    @(negedge i_clk);
    chk(8'(tariff), 8'h02);
    complete_run();
  end
endmodule // testbench
